// file: verilog/trh_pkg.sv
/*
  Package for the triggered read cycle handshake block: image sizes and
  identifiers, refresh and timeout limits, register offsets and bit layouts.
  Assumes a single 100 MHz clock domain.
*/
package trh_pkg;

  // Image identifiers and sizes in bytes
  localparam logic [7:0]  RESULT_IMG_ID      = 8'h64;
  localparam logic [8:0]  RESULT_IMG_BYTES   = 9'h1ec;
  localparam logic [8:0]  RESULT_DATA_BYTES  = 9'h1b8;
  localparam logic [7:0]  CMD_IMG_ID         = 8'hc5;
  localparam logic [8:0]  CMD_IMG_BYTES      = 9'h11c;

  // Refresh interval limits in units of 100 us and timeout multiplier limits
  localparam logic [15:0] RPI_MIN_100US      = 16'h0050;
  localparam logic [15:0] RPI_MAX_100US      = 16'h028a;
  localparam logic [15:0] RPI_DEF_100US      = 16'h00c8;
  localparam logic [9:0]  TMO_MULT_MIN       = 10'h004;
  localparam logic [9:0]  TMO_MULT_MAX       = 10'h200;
  localparam logic [9:0]  TMO_MULT_DEF       = 10'h004;
  localparam logic [15:0] TMO_MIN_100US      = 16'h0064;

  // Clock and derived tick
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          TICK_NS            = 100000;
  localparam int          TICK_CYCLES        = TICK_NS / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [3:0]  REG_CTRL           = 4'h0;
  localparam logic [3:0]  REG_STATUS         = 4'h1;
  localparam logic [3:0]  REG_TAGS           = 4'h2;
  localparam logic [3:0]  REG_RPI            = 4'h3;
  localparam logic [3:0]  REG_TMO            = 4'h4;
  localparam logic [3:0]  REG_IRQ_STAT       = 4'h5;
  localparam logic [3:0]  REG_IRQ_MASK       = 4'h6;
  localparam logic [3:0]  REG_IMG_INFO       = 4'h7;

  // Control register fields
  localparam int          CTRL_CONN_BIT      = 0;
  localparam int          CTRL_CAPS_LSB      = 4;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0010;

  // Interrupt bits
  localparam int          IRQ_TRIG           = 0;
  localparam int          IRQ_CAPDONE        = 1;
  localparam int          IRQ_REPORT         = 2;
  localparam int          IRQ_TIMEOUT        = 3;
  localparam int          IRQ_W              = 4;

  typedef enum logic [1:0] {
    TRH_IDLE    = 2'b00,
    TRH_CAPTURE = 2'b01,
    TRH_GAP     = 2'b10
  } trh_cap_e;

endpackage

// file: verilog/trh_report_mem.sv
/*
  Small result-report memory: one spare bit, written as zero, and a sequence tag per entry,
  written by the cycle engine and read with registered data.
  Assumes one clock and a synchronous write port.
*/
`timescale 1ns/100ps
module trh_report_mem #(
  parameter int AW = 2,
  parameter int DW = 9
) (
  // Clock
  input  wire logic          ref_clk_i,
  input  wire logic          clk_en_i,
  // Write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  // Read port
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i && wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule

// file: verilog/trh_core.sv
/*
  Reader-side trigger handshake: trigger echo, capture flags, read and
  finished sequence tags, pass flag, refresh timeout watch and registers.
  Assumes the command image trigger bit and image-engine events arrive
  synchronous to ref_clk_i.
*/
`timescale 1ns/100ps
module trh_core
  import trh_pkg::*;
#(
  parameter int TAG_W      = 8,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             clk_en_i,
  // Connection
  input  wire logic             conn_open_i,
  input  wire logic             cmd_img_valid_i,
  input  wire logic             trigger_i,
  // Image engine
  input  wire logic             cap_start_i,
  input  wire logic             cap_end_i,
  input  wire logic             decode_start_i,
  input  wire logic             report_valid_i,
  input  wire logic             report_pass_i,
  // Handshake outputs
  output logic                  trig_echo_o,
  output logic                  cap_done_o,
  output logic                  cap_idle_o,
  output logic      [TAG_W-1:0] read_sequence_tag_o,
  output logic      [TAG_W-1:0] finished_sequence_tag_o,
  output logic                  read_pass_o,
  output logic                  cycle_start_o,
  output logic                  conn_timeout_o,
  // Register port
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  output logic                  irq_o
);

  logic             trig_q;
  logic [31:0]      ctrl_q;
  logic [15:0]      rpi_q;
  logic [9:0]       tmo_mult_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  trh_cap_e         cap_q;
  logic [3:0]       caps_left_q;
  logic             first_dec_q;
  logic [1:0]       wr_ptr_q;
  logic [1:0]       rd_ptr_q;
  logic [2:0]       pend_q;
  logic             rd_valid_q;
  logic [TAG_W:0]   mem_rdata;
  logic [25:0]      tmo_cnt_q;
  logic [31:0]      tick_cnt_q;
  logic             trig_rise;
  logic             link_up;
  logic             rpt_ready;
  logic [25:0]      tmo_limit;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Only an open originator connection moves images
  assign link_up   = conn_open_i && ctrl_q[CTRL_CONN_BIT] && !conn_timeout_o;
  assign trig_rise = link_up && cmd_img_valid_i && trigger_i && !trig_q;
  // Timeout = interval x multiplier, floor 10.1 ms
  assign tmo_limit = (26'(rpi_q) * 26'(tmo_mult_q) > 26'(TMO_MIN_100US)) ?
                     26'(rpi_q) * 26'(tmo_mult_q) : 26'(TMO_MIN_100US) + 26'h1;

  // Trigger sampled from the command image
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      trig_q <= 1'b0;
    end else if (clk_en_i && link_up && cmd_img_valid_i) begin
      trig_q <= trigger_i;
    end
  end

  // Echo follows the detected trigger level
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      trig_echo_o <= 1'b0;
    end else if (clk_en_i) begin
      trig_echo_o <= trig_q;
    end
  end

  assign cycle_start_o = clk_en_i && trig_rise && (cap_q == TRH_IDLE);

  // Capture sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cap_q       <= TRH_IDLE;
      caps_left_q <= 4'h0;
      cap_done_o  <= 1'b1;
      cap_idle_o  <= 1'b1;
    end else if (clk_en_i) begin
      unique case (cap_q)
        TRH_IDLE: begin
          if (cycle_start_o) begin
            cap_q       <= TRH_CAPTURE;
            caps_left_q <= ctrl_q[CTRL_CAPS_LSB +: 4];
            cap_done_o  <= 1'b0;
            cap_idle_o  <= 1'b0;
          end
        end
        TRH_CAPTURE: begin
          if (cap_end_i) begin
            if (caps_left_q <= 4'h1) begin
              cap_q      <= TRH_IDLE;
              cap_done_o <= 1'b1;
              cap_idle_o <= 1'b1;
            end else begin
              cap_q       <= TRH_GAP;
              caps_left_q <= caps_left_q - 4'h1;
              cap_done_o  <= 1'b1;
              cap_idle_o  <= 1'b1;
            end
          end
        end
        TRH_GAP: begin
          if (cap_start_i) begin
            cap_q      <= TRH_CAPTURE;
            cap_done_o <= 1'b0;
            cap_idle_o <= 1'b0;
          end
        end
      endcase
    end
  end

  // Read tag bumps once per cycle at first decode
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      read_sequence_tag_o <= '0;
      first_dec_q         <= 1'b0;
    end else if (clk_en_i) begin
      if (cycle_start_o) begin
        first_dec_q <= 1'b1;
      end else if (decode_start_i && first_dec_q) begin
        first_dec_q         <= 1'b0;
        read_sequence_tag_o <= read_sequence_tag_o + TAG_W'(1);
      end
    end
  end

  // Pending cycle tags queued until their reports arrive
  trh_report_mem #(
    .AW (2),
    .DW (TAG_W + 1)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .clk_en_i  (clk_en_i),
    .wr_en_i   (decode_start_i && first_dec_q),
    .wr_addr_i (wr_ptr_q),
    .wr_data_i ({1'b0, read_sequence_tag_o + TAG_W'(1)}),
    .rd_addr_i (rd_ptr_q),
    .rd_data_o (mem_rdata)
  );

  // Reports must trail decode start and each other by two cycles or more;
  // the registered queue read needs one cycle to show the next entry.
  assign rpt_ready = report_valid_i && (pend_q != 3'h0);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      pend_q   <= 3'h0;
    end else if (clk_en_i) begin
      if (decode_start_i && first_dec_q) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (rpt_ready) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
      pend_q <= pend_q + 3'((decode_start_i && first_dec_q) ? 1 : 0) - 3'(rpt_ready ? 1 : 0);
    end
  end

  // Finished tag and pass flag update together with the report
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rd_valid_q <= 1'b0;
    end else if (clk_en_i) begin
      rd_valid_q <= rpt_ready;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      finished_sequence_tag_o <= '0;
      read_pass_o             <= 1'b0;
    end else if (clk_en_i && rpt_ready) begin
      finished_sequence_tag_o <= mem_rdata[TAG_W-1:0];
      read_pass_o             <= report_pass_i;
    end
  end

  // Refresh watchdog in 100 us ticks
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tick_cnt_q     <= '0;
      tmo_cnt_q      <= '0;
      conn_timeout_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!conn_open_i || cmd_img_valid_i) begin
        tick_cnt_q     <= '0;
        tmo_cnt_q      <= '0;
        conn_timeout_o <= 1'b0;
      end else if (tick_cnt_q == 32'(TICK_COUNT - 1)) begin
        tick_cnt_q <= '0;
        if (tmo_cnt_q >= tmo_limit - 26'h1) begin
          conn_timeout_o <= 1'b1;
        end else begin
          tmo_cnt_q <= tmo_cnt_q + 26'h1;
        end
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_q     <= CTRL_RESET;
      rpi_q      <= RPI_DEF_100US;
      tmo_mult_q <= TMO_MULT_DEF;
      irq_mask_q <= '0;
    end else if (clk_en_i && reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL:     ctrl_q     <= reg_wdata_i;
        REG_RPI:      rpi_q      <= clamp16(reg_wdata_i[15:0], RPI_MIN_100US, RPI_MAX_100US);
        REG_TMO:      tmo_mult_q <= 10'(clamp16(reg_wdata_i[15:0], 16'(TMO_MULT_MIN),
                                                 16'(TMO_MULT_MAX)));
        REG_IRQ_MASK: irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a set beats a same-cycle clear
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irq_stat_q <= '0;
    end else if (clk_en_i) begin
      irq_stat_q <= (irq_stat_q & ~((reg_wr_i && reg_addr_i == REG_IRQ_STAT) ? reg_wdata_i[IRQ_W-1:0] : '0))
                  | {conn_timeout_o, rpt_ready, (cap_q == TRH_CAPTURE) && cap_end_i && caps_left_q <= 4'h1,
                     cycle_start_o};
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Read data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= '0;
    end else if (clk_en_i) begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          REG_CTRL:     reg_rdata_o <= ctrl_q;
          REG_STATUS:   reg_rdata_o <= {23'h0, pend_q, conn_timeout_o, link_up, read_pass_o,
                                        cap_idle_o, cap_done_o, trig_echo_o};
          REG_TAGS:     reg_rdata_o <= {16'h0, 8'(finished_sequence_tag_o), 8'(read_sequence_tag_o)};
          REG_RPI:      reg_rdata_o <= {16'h0, rpi_q};
          REG_TMO:      reg_rdata_o <= {22'h0, tmo_mult_q};
          REG_IRQ_STAT: reg_rdata_o <= {28'h0, irq_stat_q};
          REG_IRQ_MASK: reg_rdata_o <= {28'h0, irq_mask_q};
          REG_IMG_INFO: reg_rdata_o <= {RESULT_IMG_ID, RESULT_IMG_BYTES[7:0], CMD_IMG_ID,
                                        CMD_IMG_BYTES[7:0]};
          default:      reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // Checks
  echo_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clk_en_i |=> trig_echo_o == $past(trig_q)) else $error("echo not following trigger");
  cap_low_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cap_q == TRH_CAPTURE |-> !cap_done_o && !cap_idle_o) else $error("flags high in capture");
  gap_high_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cap_q == TRH_GAP |-> cap_done_o && cap_idle_o) else $error("flags low between captures");
  idle_flags_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cap_q == TRH_IDLE |-> cap_done_o && cap_idle_o) else $error("flags low when idle");
  start_cap_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cycle_start_o |=> cap_q == TRH_CAPTURE) else $error("trigger did not start capture");
  tag_bump_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clk_en_i && decode_start_i && first_dec_q |=> read_sequence_tag_o == $past(read_sequence_tag_o) + TAG_W'(1))
    else $error("read tag not bumped");
  pass_rpt_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clk_en_i && rpt_ready |=> read_pass_o == $past(report_pass_i)) else $error("pass flag wrong");
  rpi_range_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    rpi_q >= RPI_MIN_100US && rpi_q <= RPI_MAX_100US) else $error("interval out of range");
  tmo_range_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    tmo_mult_q >= TMO_MULT_MIN && tmo_mult_q <= TMO_MULT_MAX && tmo_limit > 26'(TMO_MIN_100US))
    else $error("timeout out of range");
  fin_tag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clk_en_i && rpt_ready |=> finished_sequence_tag_o == $past(mem_rdata[TAG_W-1:0]))
    else $error("finished tag mismatch");
  tag_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clk_en_i && !(decode_start_i && first_dec_q) |=> $stable(read_sequence_tag_o))
    else $error("read tag moved without decode");
  fin_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    clk_en_i && !rpt_ready |=> $stable(finished_sequence_tag_o) && $stable(read_pass_o))
    else $error("report outputs moved without report");
  cap_pair_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    cap_done_o == cap_idle_o) else $error("capture flags split");
  tmo_link_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    conn_timeout_o |-> !link_up) else $error("link up after timeout");
  clk_freeze_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !clk_en_i |=> $stable(cap_q) && $stable(read_sequence_tag_o) && $stable(rpi_q) && $stable(irq_stat_q))
    else $error("state moved while frozen");

endmodule

// file: dv/trh_plc_model.sv
/*
  Controller model: sends a command image each cycle unless quiet_i is set, raises the trigger
  bit on request and counts new reports.
  Assumes the reader handshake outputs of trh_core on the same clock.
*/
`timescale 1ns/100ps
module trh_plc_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Bench control
  input  wire logic       req_i,
  input  wire logic       quiet_i,
  // Reader side
  input  wire logic       trig_echo_i,
  input  wire logic       cap_idle_i,
  input  wire logic [7:0] fin_tag_i,
  output logic            cmd_img_valid_o,
  output logic            trigger_o,
  output logic [7:0]      reports_o
);
  logic       pend_q;
  logic [7:0] seen_q;

  always_ff @(posedge ref_clk_i) begin
    cmd_img_valid_o <= resetn_i && !quiet_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pend_q    <= 1'b0;
      trigger_o <= 1'b0;
    end else if (!trigger_o && pend_q && cap_idle_i && !trig_echo_i) begin
      pend_q    <= 1'b0;
      trigger_o <= 1'b1;
    end else begin
      pend_q <= pend_q | req_i;
      if (trig_echo_i) begin
        trigger_o <= 1'b0;
      end
    end
  end

  // New report when the finished tag moves
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      seen_q    <= 8'h00;
      reports_o <= 8'h00;
    end else if (fin_tag_i != seen_q) begin
      seen_q    <= fin_tag_i;
      reports_o <= reports_o + 8'h01;
    end
  end
endmodule

// file: dv/triggered_read_cycle_handshake_tb_top.sv
/*
  Testbench for trh_core with a controller model on the command side.
  Assumes one 100 MHz clock and a shortened tick of 2 cycles.
*/
`timescale 1ns/100ps
module triggered_read_cycle_handshake_tb_top
  import trh_pkg::*;
;
  localparam int TMO_CYC = 2 * 200 * 4;
  logic        ref_clk_i, resetn_i, clk_en_i, conn_open_i, cmd_img_valid_i, trigger_i;
  logic        cap_start_i, cap_end_i, decode_start_i, report_valid_i, report_pass_i;
  logic        trig_echo_o, cap_done_o, cap_idle_o, read_pass_o, cycle_start_o, conn_timeout_o;
  logic [7:0]  read_sequence_tag_o, finished_sequence_tag_o, reports;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic        reg_wr_i, reg_rd_i, irq_o, req, quiet, ia, ib;
  int          mismatches, n_compared, cycles;

  trh_core #(.TAG_W(8), .TICK_COUNT(2)) u_dut (
    .ref_clk_i, .resetn_i, .clk_en_i, .conn_open_i, .cmd_img_valid_i, .trigger_i,
    .cap_start_i, .cap_end_i, .decode_start_i, .report_valid_i, .report_pass_i,
    .trig_echo_o, .cap_done_o, .cap_idle_o, .read_sequence_tag_o, .finished_sequence_tag_o,
    .read_pass_o, .cycle_start_o, .conn_timeout_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o
  );

  trh_plc_model u_plc (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req), .quiet_i(quiet),
    .trig_echo_i(trig_echo_o), .cap_idle_i(cap_idle_o), .fin_tag_i(finished_sequence_tag_o),
    .cmd_img_valid_o(cmd_img_valid_i), .trigger_o(trigger_i), .reports_o(reports)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    cycles = 0;
    forever begin
      @(posedge ref_clk_i);
      cycles++;
      if (cycles == 20000) begin
        mismatches++;
        $display("[FAIL] watchdog expected end seen hang");
        wrap_up();
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(nm, e, reg_rdata_o & m);
  endtask

  // Engine events: cap_start 8, cap_end 4, decode_start 2, report 1
  task automatic ev(input logic [3:0] m, input logic p);
    @(posedge ref_clk_i);
    {cap_start_i, cap_end_i, decode_start_i, report_valid_i} <= m;
    report_pass_i <= p;
    @(posedge ref_clk_i);
    {cap_start_i, cap_end_i, decode_start_i, report_valid_i} <= 4'h0;
    @(negedge ref_clk_i);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return cycle_start_o;
      1: return trig_echo_o;
      default: return conn_timeout_o;
    endcase
  endfunction

  task automatic await(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("await", v, sig(s));
  endtask

  task automatic trig();
    @(posedge ref_clk_i);
    req <= 1'b1;
    @(posedge ref_clk_i);
    req <= 1'b0;
    await(0, 1'b1, 50);
    @(negedge ref_clk_i);
    chk("cap_flags", 0, {cap_done_o, cap_idle_o});
    await(1, 1'b1, 50);
    await(1, 1'b0, 50);
    chk("cap_flags", 0, {cap_done_o, cap_idle_o});
  endtask

  initial begin
    {resetn_i, conn_open_i, cap_start_i, cap_end_i, decode_start_i, report_valid_i} = '0;
    {report_pass_i, reg_wr_i, reg_rd_i, req, quiet} = '0;
    clk_en_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0000_0000;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    conn_open_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("echo", 0, trig_echo_o);
    chk("cap_flags", 3, {cap_done_o, cap_idle_o});
    chk("tags", 0, {finished_sequence_tag_o, read_sequence_tag_o});
    chk("pass_irq", 0, {read_pass_o, irq_o});
    rdc("ctrl", REG_CTRL, 32'hffff_ffff, CTRL_RESET);
    rdc("status", REG_STATUS, 32'h0000_00ef, 32'h0000_0006);
    rdc("rpi", REG_RPI, 32'h0000_ffff, {16'h0000, RPI_DEF_100US});
    rdc("tmo", REG_TMO, 32'h0000_03ff, {22'h0, TMO_MULT_DEF});
    rdc("unmapped", 4'h8, 32'hffff_ffff, 32'h0000_0000);
    rdc("img_info", REG_IMG_INFO, 32'hffff_ffff, 32'h64ec_c51c);
    $display("test reset done");

    wr(REG_RPI, 32'h0000_004f);
    rdc("rpi_lo", REG_RPI, 32'h0000_ffff, {16'h0000, RPI_MIN_100US});
    wr(REG_RPI, 32'h0000_028b);
    rdc("rpi_hi", REG_RPI, 32'h0000_ffff, {16'h0000, RPI_MAX_100US});
    wr(REG_TMO, 32'h0000_0003);
    rdc("tmo_lo", REG_TMO, 32'h0000_03ff, {22'h0, TMO_MULT_MIN});
    wr(REG_TMO, 32'h0000_0201);
    rdc("tmo_hi", REG_TMO, 32'h0000_03ff, {22'h0, TMO_MULT_MAX});
    wr(REG_RPI, {16'h0000, RPI_DEF_100US});
    wr(REG_TMO, {22'h0, TMO_MULT_DEF});
    $display("test limits done");

    wr(REG_CTRL, 32'h0000_0011);
    trig();
    ev(4'h2, 1'b0);
    chk("read_tag", 1, read_sequence_tag_o);
    ev(4'h4, 1'b0);
    chk("cap_flags", 3, {cap_done_o, cap_idle_o});
    trig();
    ev(4'h2, 1'b0);
    chk("read_tag", 2, read_sequence_tag_o);
    ev(4'h4, 1'b0);
    ev(4'h1, 1'b1);
    chk("fin_pass", 32'h0000_0003, {finished_sequence_tag_o, read_pass_o});
    ev(4'h1, 1'b0);
    chk("fin_pass", 32'h0000_0004, {finished_sequence_tag_o, read_pass_o});
    rdc("tags", REG_TAGS, 32'h0000_ffff, 32'h0000_0202);
    chk("reports", 2, reports);
    $display("test cycles done");

    wr(REG_CTRL, 32'h0000_0021);
    trig();
    ev(4'h4, 1'b0);
    chk("gap_flags", 3, {cap_done_o, cap_idle_o});
    ev(4'h8, 1'b0);
    chk("next_cap", 0, {cap_done_o, cap_idle_o});
    ev(4'h4, 1'b0);
    chk("cap_flags", 3, {cap_done_o, cap_idle_o});
    $display("test multi done");

    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    wr(REG_RPI, 32'h0000_0100);
    clk_en_i <= 1'b1;
    rdc("rpi_frz", REG_RPI, 32'h0000_ffff, {16'h0000, RPI_DEF_100US});
    $display("test freeze done");

    rdc("irq_stat", REG_IRQ_STAT, 32'h0000_000f, 32'h0000_0007);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    @(negedge ref_clk_i);
    ia = irq_o;
    wr(REG_IRQ_MASK, 32'h0000_000f);
    @(negedge ref_clk_i);
    ib = irq_o;
    chk("irq_mask", 1, ia ^ ib);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    rdc("irq_clr", REG_IRQ_STAT, 32'h0000_000f, 32'h0000_0000);
    chk("irq", 0, irq_o);
    $display("test irq done");

    quiet <= 1'b1;
    repeat (TMO_CYC - 100) @(negedge ref_clk_i);
    chk("early_tmo", 0, conn_timeout_o);
    await(2, 1'b1, 200);
    rdc("irq_tmo", REG_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    quiet <= 1'b0;
    await(2, 1'b0, 50);
    $display("test timeout done");
    wrap_up();
  end
endmodule
